// file: verilog/rmpc_pkg.sv
// constants, register map and state codes of the mode and polling
// controller; assumes a 25 MHz system clock
package rmpc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_MODE_PRI = 8'h02;
	localparam logic [7:0] ADDR_MODE_SEC = 8'h03;
	localparam logic [7:0] ADDR_CFGA_MOD = 8'h21;
	localparam logic [7:0] ADDR_CFGB_MOD = 8'h42;
	localparam logic [7:0] ADDR_FOUND_CH = 8'h7F;

	localparam logic [7:0] RST_MODE_PRI  = 8'h40;
	localparam logic [7:0] RST_MODE_SEC  = 8'h00;
	localparam logic [7:0] RST_CFG_MOD   = 8'h04;
	localparam logic [1:0] RST_FOUND     = 2'h0;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_MODE_SEL   = 0;
	localparam int BIT_SLAVE_EN   = 1;
	localparam int BIT_DUAL_CFG   = 2;
	localparam int BIT_SLAVE_CFGB = 3;
	localparam int BIT_HOLD       = 6;
	localparam int CNT_LSB        = 2;
	localparam int MOD_LSB        = 0;

	localparam logic [1:0] CH_ONE = 2'h1;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 40;
	localparam int SETTLE_TIME_NS = 40000;
	localparam int SETTLE_CYCLES  =
		(SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W       = $clog2(SETTLE_CYCLES + 1);
	localparam logic [SETTLE_W-1:0] SETTLE_LAST =
		SETTLE_W'(SETTLE_CYCLES - 1);
	localparam logic [SETTLE_W-1:0] SETTLE_FULL =
		SETTLE_W'(SETTLE_CYCLES);

	// ****************************************
	// serial port framing
	// ****************************************
	localparam logic [7:0] SPI_CMD_WRITE = 8'h02;
	localparam logic [4:0] SPI_CMD_BIT   = 5'h07;
	localparam logic [4:0] SPI_ADDR_BIT  = 5'h0F;
	localparam logic [4:0] SPI_DATA_BIT  = 5'h10;
	localparam logic [4:0] SPI_LAST_BIT  = 5'h17;
	localparam logic [4:0] SPI_END       = 5'h18;

	// ****************************************
	// controller states
	// ****************************************
	typedef enum logic [16:0] {
		ST_SLEEP       = 17'h00001,
		ST_STARTUP     = 17'h00002,
		ST_S_INIT      = 17'h00004,
		ST_SLAVE_RUN   = 17'h00008,
		ST_HOLD        = 17'h00010,
		ST_P_IDLE      = 17'h00020,
		ST_P_WAIT      = 17'h00040,
		ST_P_LOOP_INIT = 17'h00080,
		ST_P_MOD       = 17'h00100,
		ST_P_CFG_INIT  = 17'h00200,
		ST_P_LOAD      = 17'h00400,
		ST_P_SETTLE    = 17'h00800,
		ST_P_SEARCH    = 17'h01000,
		ST_P_STORE     = 17'h02000,
		ST_P_COMPARE   = 17'h04000,
		ST_P_INC       = 17'h08000,
		ST_P_RUN       = 17'h10000
	} rmpc_state_t;

endpackage

// file: verilog/rmpc_spi_port.sv
// serial register port: 24-bit frames of command, address, data
// assumes spi mode 0, msb first, sclk at most a eighth of the clock
`timescale 1ns/1ps
module rmpc_spi_port
	import rmpc_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// raw pins
	input  wire logic       i_sclk,
	input  wire logic       i_csn,
	input  wire logic       i_sdi,
	output logic            o_sdo,
	// register side
	output logic            o_wr_stb,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wdata,
	input  wire logic [7:0] i_rdata
);

	logic [2:0] sclk_q;
	logic [1:0] csn_q;
	logic [1:0] sdi_q;
	logic [4:0] bit_q;
	logic [7:0] shift_q;
	logic [7:0] cmd_q;
	logic [7:0] out_q;
	logic       load_q;
	logic       rise;
	logic       fall;
	logic [7:0] byte_in;

	// edges seen only past the second stage
	assign rise    = sclk_q[1] & ~sclk_q[2] & ~csn_q[1];
	assign fall    = ~sclk_q[1] & sclk_q[2] & ~csn_q[1];
	assign byte_in = {shift_q[6:0], sdi_q[1]};
	assign o_sdo   = out_q[7];

	// pin synchronisers
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sclk_q <= 3'h0;
			csn_q  <= 2'h3;
			sdi_q  <= 2'h0;
		end
		else
		begin
			sclk_q <= {sclk_q[1:0], i_sclk};
			csn_q  <= {csn_q[0], i_csn};
			sdi_q  <= {sdi_q[0], i_sdi};
		end
	end

	// frame shifter
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			bit_q    <= 5'h00;
			shift_q  <= 8'h00;
			cmd_q    <= 8'h00;
			o_addr   <= 8'h00;
			o_wdata  <= 8'h00;
			o_wr_stb <= 1'b0;
			out_q    <= 8'h00;
			load_q   <= 1'b0;
		end
		else
		begin
			o_wr_stb <= 1'b0;
			load_q   <= 1'b0;
			if (csn_q[1])
				bit_q <= 5'h00;
			else if (rise && bit_q != SPI_END)
			begin
				shift_q <= byte_in;
				bit_q   <= bit_q + 5'h01;
				if (bit_q == SPI_CMD_BIT)
					cmd_q <= byte_in;
				if (bit_q == SPI_ADDR_BIT)
				begin
					o_addr <= byte_in;
					load_q <= 1'b1;
				end
				if (bit_q == SPI_LAST_BIT && cmd_q == SPI_CMD_WRITE)
				begin
					o_wdata  <= byte_in;
					o_wr_stb <= 1'b1;
				end
			end
			// read data leave on falling edges of the data byte
			if (load_q)
				out_q <= i_rdata;
			else if (fall && bit_q > SPI_DATA_BIT)
				out_q <= {out_q[6:0], 1'b0};
		end
	end

endmodule

// file: verilog/rmpc_top.sv
// mode controller and self-polling scheduler of the receiver
// assumes start-up sequencer, polling timer and wake-up search
// units on the same clock; registers reached over the serial port
`timescale 1ns/1ps
module rmpc_top
	import rmpc_pkg::*;
(
	// clock and reset
	input  wire logic       I_CLOCK,
	input  wire logic       I_RSTN,
	// serial register port
	input  wire logic       I_SPI_SCLK,
	input  wire logic       I_SPI_CSN,
	input  wire logic       I_SPI_SDI,
	output logic            O_SPI_SDO,
	// polling timer and start-up sequencer
	input  wire logic       I_RX_RUN,
	input  wire logic       I_STARTUP_DONE,
	output logic            O_STARTUP_REQ,
	// wake-up search unit
	input  wire logic       I_SEARCH_DONE,
	input  wire logic       I_WAKEUP_FOUND,
	output logic            O_SEARCH_START,
	// receiver control
	output logic            O_RF_POWER_ON,
	output logic            O_OSC_HIGH_PREC,
	output logic            O_RX_INIT,
	output logic            O_SYNTH_LOAD,
	output logic [1:0]      O_SYNTH_CHANNEL,
	output logic            O_CONFIG_B,
	output logic [1:0]      O_MOD_TYPE,
	// mode status
	output logic            O_SLAVE_RUN,
	output logic            O_HOLD_ACTIVE,
	output logic            O_SELF_POLL_RUN,
	output logic [1:0]      O_FOUND_CHANNEL
);

	// ****************************************
	// register port
	// ****************************************
	logic              wr_stb;
	logic [7:0]        wr_addr;
	logic [7:0]        wr_data;
	logic [7:0]        rd_data;
	logic              sdo;
	logic [7:0]        mode_pri_q;
	logic [7:0]        mode_sec_q;
	logic [7:0]        cfga_q;
	logic [7:0]        cfgb_q;
	logic [1:0]        found_q;
	logic [1:0]        found_d;
	logic              cfg_wr;

	rmpc_spi_port u_spi (
		.i_clk   (I_CLOCK),
		.i_rstn  (I_RSTN),
		.i_sclk  (I_SPI_SCLK),
		.i_csn   (I_SPI_CSN),
		.i_sdi   (I_SPI_SDI),
		.o_sdo   (sdo),
		.o_wr_stb(wr_stb),
		.o_addr  (wr_addr),
		.o_wdata (wr_data),
		.i_rdata (rd_data)
	);

	// only the found channel reads back, rest zero
	assign rd_data = (wr_addr == ADDR_FOUND_CH) ?
		{6'h00, found_q} : 8'h00;
	assign cfg_wr  = wr_stb && (wr_addr == ADDR_MODE_PRI ||
		wr_addr == ADDR_MODE_SEC || wr_addr == ADDR_CFGA_MOD ||
		wr_addr == ADDR_CFGB_MOD);

	// write-only configuration registers
	always_ff @(posedge I_CLOCK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			mode_pri_q <= RST_MODE_PRI;
			mode_sec_q <= RST_MODE_SEC;
			cfga_q     <= RST_CFG_MOD;
			cfgb_q     <= RST_CFG_MOD;
		end
		else if (wr_stb)
		begin
			if (wr_addr == ADDR_MODE_PRI)
				mode_pri_q <= wr_data;
			if (wr_addr == ADDR_MODE_SEC)
				mode_sec_q <= wr_data;
			if (wr_addr == ADDR_CFGA_MOD)
				cfga_q <= wr_data;
			if (wr_addr == ADDR_CFGB_MOD)
				cfgb_q <= wr_data;
		end
	end

	// ****************************************
	// mode decode
	// ****************************************
	rmpc_state_t       state_q;
	rmpc_state_t       state_d;
	logic              want_poll;
	logic              want_slave;
	logic              want_sleep;
	logic              hold_bit;
	logic              dual;
	logic              slave_grp;
	logic              poll_grp;
	logic              scan_grp;
	logic              cfg_b_q;
	logic              cfg_b_d;
	logic              use_b;
	logic [7:0]        sel_cfg;
	logic [1:0]        count;
	logic [1:0]        chan_q;
	logic [1:0]        chan_d;
	logic              last_chan;
	logic [SETTLE_W-1:0] settle_q;
	logic [SETTLE_W-1:0] age_q;
	logic              aged;

	assign want_poll  = mode_pri_q[BIT_MODE_SEL];
	// slave enable only counts in slave mode
	assign want_slave = !want_poll && mode_pri_q[BIT_SLAVE_EN];
	assign want_sleep = !want_poll && !mode_pri_q[BIT_SLAVE_EN];
	assign hold_bit   = mode_sec_q[BIT_HOLD];
	assign dual       = mode_pri_q[BIT_DUAL_CFG];
	assign aged       = (age_q == SETTLE_FULL);

	assign slave_grp = (state_q == ST_STARTUP) ||
		(state_q == ST_S_INIT) || (state_q == ST_SLAVE_RUN) ||
		(state_q == ST_HOLD);
	assign scan_grp  = (state_q == ST_P_WAIT) ||
		(state_q == ST_P_LOOP_INIT) || (state_q == ST_P_MOD) ||
		(state_q == ST_P_CFG_INIT) || (state_q == ST_P_LOAD) ||
		(state_q == ST_P_SETTLE) || (state_q == ST_P_SEARCH) ||
		(state_q == ST_P_COMPARE) || (state_q == ST_P_INC);
	assign poll_grp  = scan_grp || (state_q == ST_P_IDLE) ||
		(state_q == ST_P_STORE) || (state_q == ST_P_RUN);

	// config B in the second pass of a dual loop, or in slave mode from the slave config B bit
	assign use_b     = want_poll ? cfg_b_q :
		mode_pri_q[BIT_SLAVE_CFGB];
	assign sel_cfg   = use_b ? cfgb_q : cfga_q;
	// count taken from the active configuration
	assign count     = sel_cfg[CNT_LSB +: 2];
	assign last_chan = (chan_q >= count);

	// ****************************************
	// state machine
	// ****************************************
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_SLEEP:
				if (want_slave)
					state_d = ST_STARTUP;
				else if (want_poll)
					state_d = ST_P_IDLE;
			ST_STARTUP:
				if (I_STARTUP_DONE)
					state_d = ST_S_INIT;
			ST_S_INIT:
				state_d = ST_SLAVE_RUN;
			ST_SLAVE_RUN:
				if (hold_bit)
					state_d = ST_HOLD;
			ST_HOLD:
				if (!hold_bit && aged)
					state_d = ST_S_INIT;
			ST_P_IDLE:
				if (I_RX_RUN)
					state_d = ST_P_WAIT;
			ST_P_WAIT:
				if (I_STARTUP_DONE)
					state_d = ST_P_LOOP_INIT;
			ST_P_LOOP_INIT:
				state_d = ST_P_MOD;
			ST_P_MOD:
				state_d = ST_P_CFG_INIT;
			ST_P_CFG_INIT:
				state_d = ST_P_LOAD;
			ST_P_LOAD:
				state_d = ST_P_SETTLE;
			ST_P_SETTLE:
				if (settle_q == '0)
					state_d = ST_P_SEARCH;
			ST_P_SEARCH:
				if (I_SEARCH_DONE)
					state_d = I_WAKEUP_FOUND ? ST_P_STORE :
						ST_P_COMPARE;
			ST_P_STORE:
				state_d = ST_P_RUN;
			ST_P_COMPARE:
				// end of loop or next channel
				if (!last_chan)
					state_d = ST_P_INC;
				else if (dual && !cfg_b_q)
					state_d = ST_P_LOOP_INIT;
				else
					state_d = ST_P_IDLE;
			ST_P_INC:
				state_d = ST_P_LOAD;
			ST_P_RUN:
				state_d = ST_P_RUN;
			default:
				state_d = ST_SLEEP;
		endcase
		// timer off time ends a scan
		if (scan_grp && !I_RX_RUN)
			state_d = ST_P_IDLE;
		if ((slave_grp && !want_slave) || (poll_grp && !want_poll))
			state_d = ST_SLEEP;
	end

	assign cfg_b_d = (state_q == ST_P_COMPARE &&
		state_d == ST_P_LOOP_INIT) ? 1'b1 :
		(state_d == ST_P_IDLE || state_d == ST_SLEEP) ? 1'b0 :
		cfg_b_q;

	assign chan_d = (state_d == ST_P_LOOP_INIT ||
		state_d == ST_S_INIT) ? CH_ONE :
		(state_q == ST_P_INC) ? chan_q + 2'h1 : chan_q;

	// store channel; channel three is 11b
	assign found_d = (state_q == ST_P_STORE) ? chan_q : found_q;

	// state, loop and found-channel registers
	always_ff @(posedge I_CLOCK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			state_q <= ST_SLEEP;
			cfg_b_q <= 1'b0;
			chan_q  <= CH_ONE;
			found_q <= RST_FOUND;
		end
		else
		begin
			state_q <= state_d;
			cfg_b_q <= cfg_b_d;
			chan_q  <= chan_d;
			found_q <= found_d;
		end
	end

	// settle counter loaded with each channel
	always_ff @(posedge I_CLOCK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			settle_q <= '0;
		else if (state_q == ST_P_LOAD)
			settle_q <= SETTLE_LAST;
		else if (state_q == ST_P_SETTLE && settle_q != '0)
			settle_q <= settle_q - 1'b1;
	end

	always_ff @(posedge I_CLOCK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			age_q <= SETTLE_FULL;
		else if (cfg_wr)
			age_q <= '0;
		else if (!aged)
			age_q <= age_q + 1'b1;
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge I_CLOCK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			O_SPI_SDO       <= 1'b0;
			O_STARTUP_REQ   <= 1'b0;
			O_SEARCH_START  <= 1'b0;
			O_RF_POWER_ON   <= 1'b0;
			O_OSC_HIGH_PREC <= 1'b0;
			O_RX_INIT       <= 1'b0;
			O_SYNTH_LOAD    <= 1'b0;
			O_SYNTH_CHANNEL <= CH_ONE;
			O_CONFIG_B      <= 1'b0;
			O_MOD_TYPE      <= RST_CFG_MOD[MOD_LSB +: 2];
			O_SLAVE_RUN     <= 1'b0;
			O_HOLD_ACTIVE   <= 1'b0;
			O_SELF_POLL_RUN <= 1'b0;
			O_FOUND_CHANNEL <= RST_FOUND;
		end
		else
		begin
			O_SPI_SDO       <= sdo;
			O_STARTUP_REQ   <= (state_d == ST_STARTUP) ||
				(state_d == ST_P_WAIT);
			O_SEARCH_START  <= (state_d == ST_P_SEARCH) &&
				(state_q != ST_P_SEARCH);
			O_RF_POWER_ON   <= (state_d != ST_SLEEP);
			O_OSC_HIGH_PREC <= (state_d != ST_SLEEP);
			O_RX_INIT       <= (state_d == ST_S_INIT) ||
				(state_d == ST_P_CFG_INIT);
			O_SYNTH_LOAD    <= (state_d == ST_S_INIT) ||
				(state_d == ST_P_LOAD);
			O_SYNTH_CHANNEL <= chan_d;
			O_CONFIG_B      <= want_poll ? cfg_b_d :
				mode_pri_q[BIT_SLAVE_CFGB];
			if (state_d == ST_P_MOD || state_d == ST_S_INIT)
				O_MOD_TYPE <= (want_poll ? cfg_b_d : use_b) ?
					cfgb_q[MOD_LSB +: 2] : cfga_q[MOD_LSB +: 2];
			O_SLAVE_RUN     <= (state_d == ST_SLAVE_RUN);
			O_HOLD_ACTIVE   <= (state_d == ST_HOLD);
			O_SELF_POLL_RUN <= (state_d == ST_P_RUN);
			O_FOUND_CHANNEL <= found_d;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RSTN);

	logic [SETTLE_W-1:0] seen_q;

	// cycles spent settling, for the settle check
	always_ff @(posedge I_CLOCK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			seen_q <= '0;
		else if (state_q == ST_P_SETTLE)
			seen_q <= seen_q + 1'b1;
		else
			seen_q <= '0;
	end

	sequence s_scan_ok;
		I_RX_RUN && want_poll;
	endsequence

	sequence s_last_of_a;
		state_q == ST_P_COMPARE && last_chan && !cfg_b_q;
	endsequence

	a_hold_entry: assert property (
		state_q == ST_SLAVE_RUN && hold_bit && want_slave
		|=> state_q == ST_HOLD ##1 O_HOLD_ACTIVE)
		else $error("hold request not taken");
	a_sleep_power: assert property (
		state_q == ST_SLEEP |-> !O_RF_POWER_ON && !O_OSC_HIGH_PREC)
		else $error("rf powered in sleep");
	a_sleep_start: assert property (
		state_q == ST_SLEEP && want_slave
		|=> state_q == ST_STARTUP && O_STARTUP_REQ)
		else $error("slave run skipped start-up");
	a_sleep_select: assert property (
		want_sleep |=> state_q == ST_SLEEP)
		else $error("sleep not selected");
	a_poll_entry: assert property (
		state_q == ST_SLEEP && want_poll |=> state_q == ST_P_IDLE)
		else $error("self-polling not entered");
	a_idle_hold: assert property (
		state_q == ST_P_IDLE && !I_RX_RUN && want_poll
		|=> state_q == ST_P_IDLE)
		else $error("idle left without run enable");
	a_loop_reset: assert property (
		state_q == ST_P_LOOP_INIT |=> chan_q == CH_ONE)
		else $error("loop counter not at channel one");
	a_mod_init: assert property (
		state_q == ST_P_CFG_INIT |-> O_RX_INIT &&
		O_MOD_TYPE == sel_cfg[MOD_LSB +: 2])
		else $error("wrong modulation at init");
	a_settle_time: assert property (
		state_q == ST_P_SETTLE && state_d == ST_P_SEARCH
		|-> seen_q == SETTLE_LAST)
		else $error("settle time wrong");
	a_search_hit: assert property (
		(state_q == ST_P_SEARCH && I_SEARCH_DONE && I_WAKEUP_FOUND)
		and s_scan_ok |=> state_q == ST_P_STORE)
		else $error("wake-up not stored");
	a_store_run: assert property (
		state_q == ST_P_STORE && want_poll
		|=> O_FOUND_CHANNEL == $past(chan_q) && O_SELF_POLL_RUN)
		else $error("found channel not recorded");
	a_dual_loop: assert property (
		s_last_of_a ##0 dual ##0 s_scan_ok
		|=> state_q == ST_P_LOOP_INIT && cfg_b_q)
		else $error("configuration B loop missing");
	a_single_cfg: assert property (
		s_last_of_a ##0 !dual ##0 s_scan_ok
		|=> state_q == ST_P_IDLE && !cfg_b_q)
		else $error("single configuration did not end");
	a_next_chan: assert property (
		state_q == ST_P_INC ##0 s_scan_ok
		|=> state_q == ST_P_LOAD && chan_q == $past(chan_q) + 2'h1
		##1 state_q == ST_P_SETTLE)
		else $error("next channel not loaded");
	a_hold_exit: assert property (
		state_q == ST_HOLD && !aged |=> state_q != ST_S_INIT)
		else $error("reinit too soon after change");
	a_slave_chan: assert property (
		state_q == ST_S_INIT |-> O_SYNTH_CHANNEL == CH_ONE)
		else $error("slave not on one channel");

endmodule

// file: sim/rmpc_host_model.sv
// host model: writes and reads controller registers over the serial port
// assumes mode 0 frames of command, address, data, msb first
`timescale 1ns/1ps
module rmpc_host_model
	import rmpc_pkg::*;
#(
	parameter int HALF = 8
)
(
	// clock and serial pins
	input  wire logic i_clk,
	input  wire logic i_sdo,
	output logic      o_sclk,
	output logic      o_csn,
	output logic      o_sdi
);
	// pins idle: clock low, select high
	initial
	begin
		o_sclk = 1'b0;
		o_csn = 1'b1;
		o_sdi = 1'b0;
	end

	// wait n clocks, then step just past the edge
	task automatic edges(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// one 24-bit frame; answer bits sampled just before sclk rise
	task automatic frame(input logic [23:0] bits, output logic [7:0] rd);
		rd = 8'h00;
		edges(1);
		o_csn = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			o_sdi = bits[i];
			edges(HALF);
			if (i < 8)
				rd[i] = i_sdo;
			o_sclk = 1'b1;
			edges(HALF);
			o_sclk = 1'b0;
		end
		edges(HALF);
		o_csn = 1'b1;
		o_sdi = ~o_sdi; // released line shows no stale bit
		edges(4);
	endtask

	// register write and read
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] unused;
		frame({SPI_CMD_WRITE, a, d}, unused);
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		frame({8'h03, a, 8'h00}, d);
	endtask
endmodule

// file: sim/tb_top.sv
// bench of the mode and polling controller: slave, hold, sleep, polling
// assumes the host model on the serial port; the bench plays timer,
// start-up sequencer and wake-up search unit
`timescale 1ns/1ps
module tb_top
	import rmpc_pkg::*;
;
	logic       clk, rstn, rx_run, su_done, s_done, wk_found;
	logic       sclk, csn, sdi, sdo, su_req, s_start, rf_on, osc_hp;
	logic       rx_init, syn_ld, cfg_b, slv_run, hold_act, sp_run;
	logic [1:0] syn_ch, mod_t, found;
	logic [7:0] rd;
	int         bad_count, cmp_count, cyc, waited, su_cnt, t0;
	localparam int LIMIT = 40000;

	// ****************************************
	// design, host and clock
	// ****************************************
	rmpc_top dut (.I_CLOCK(clk), .I_RSTN(rstn),
		.I_SPI_SCLK(sclk), .I_SPI_CSN(csn), .I_SPI_SDI(sdi),
		.O_SPI_SDO(sdo), .I_RX_RUN(rx_run), .I_STARTUP_DONE(su_done),
		.O_STARTUP_REQ(su_req), .I_SEARCH_DONE(s_done),
		.I_WAKEUP_FOUND(wk_found), .O_SEARCH_START(s_start),
		.O_RF_POWER_ON(rf_on), .O_OSC_HIGH_PREC(osc_hp),
		.O_RX_INIT(rx_init), .O_SYNTH_LOAD(syn_ld),
		.O_SYNTH_CHANNEL(syn_ch), .O_CONFIG_B(cfg_b), .O_MOD_TYPE(mod_t),
		.O_SLAVE_RUN(slv_run), .O_HOLD_ACTIVE(hold_act),
		.O_SELF_POLL_RUN(sp_run), .O_FOUND_CHANNEL(found));
	rmpc_host_model host (.i_clk(clk), .i_sdo(sdo), .o_sclk(sclk),
		.o_csn(csn), .o_sdi(sdi));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// start-up sequencer answers on the 61st clock of a request; hang ceiling
	always @(posedge clk)
	begin
		#1;
		cyc++;
		su_cnt = su_req ? su_cnt + 1 : 0;
		su_done = (su_cnt > 60);
		if (cyc == LIMIT)
		begin
			bad_count++;
			complete_run();
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic complete_run();
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rng(input int got, input int lo, input int hi);
		cmp_count++;
		if (got < lo || got > hi)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h..%h", $time, got,
				lo, hi);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return rx_init;
			1: return syn_ld;
			2: return s_start;
			3: return su_req;
			4: return slv_run;
			default: return sp_run;
		endcase
	endfunction

	// bounded wait for a status output; waited holds the cycles
	task automatic wait_hi(input int s, input int lim);
		waited = 0;
		while (pick(s) !== 1'b1 && waited < lim)
		begin
			tick(1);
			waited++;
		end
		chk(8'(pick(s)), 8'h01);
	endtask

	// one channel: load, settle, search, then answer the search
	task automatic scan(input logic [1:0] ch, input logic cb,
		input logic [1:0] mt, input logic hit);
		wait_hi(1, 100);
		chk(8'({cfg_b, syn_ch}), 8'({cb, ch}));
		wait_hi(2, 1100);
		rng(waited, SETTLE_CYCLES - 1, SETTLE_CYCLES + 2);
		chk(8'(mod_t), 8'(mt));
		s_done = 1'b1;
		wk_found = hit;
		tick(1);
		s_done = 1'b0;
		wk_found = ~hit;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		chk(8'({rf_on, osc_hp}), 8'h00);
		chk(8'(found), 8'h00);
		host.read_reg(ADDR_FOUND_CH, rd);
		chk(rd, 8'h00);
		host.read_reg(ADDR_MODE_PRI, rd);
		chk(rd, 8'h00);
	endtask

	task automatic t_slave();
		host.write_reg(ADDR_MODE_PRI, 8'h02);
		wait_hi(3, 10);
		tick(10);
		chk(8'(slv_run), 8'h00);
		wait_hi(4, 100);
		chk(8'({rf_on, osc_hp}), 8'h03);
		chk(8'(syn_ch), 8'h01);
		host.write_reg(ADDR_MODE_SEC, 8'h40);
		chk(8'({hold_act, slv_run}), 8'h02);
		host.write_reg(ADDR_CFGA_MOD, 8'h0D);
		t0 = cyc;
		host.write_reg(ADDR_MODE_SEC, 8'h00);
		wait_hi(0, 1500);
		rng(cyc - t0, SETTLE_CYCLES - 20, SETTLE_CYCLES + 400);
		wait_hi(4, 10);
		chk(8'({mod_t, syn_ch}), 8'h05);
		host.write_reg(ADDR_MODE_PRI, 8'h00);
		chk(8'({rf_on, osc_hp, slv_run}), 8'h00);
	endtask

	task automatic t_poll_one();
		host.write_reg(ADDR_CFGA_MOD, 8'h09);
		host.write_reg(ADDR_CFGB_MOD, 8'h0E);
		host.write_reg(ADDR_MODE_PRI, 8'h01);
		tick(30);
		chk(8'({su_req, rx_init}), 8'h00);
		rx_run = 1'b1;
		wait_hi(0, 200);
		scan(2'h1, 1'b0, 2'h1, 1'b0);
		scan(2'h2, 1'b0, 2'h1, 1'b0);
		wait_hi(0, 200);
		scan(2'h1, 1'b0, 2'h1, 1'b0);
		scan(2'h2, 1'b0, 2'h1, 1'b1);
		wait_hi(5, 20);
		chk(8'(found), 8'h02);
		host.read_reg(ADDR_FOUND_CH, rd);
		chk(rd, 8'h02);
	endtask

	task automatic t_poll_two();
		host.write_reg(ADDR_MODE_PRI, 8'h00);
		chk(8'({rf_on, sp_run}), 8'h00);
		host.write_reg(ADDR_CFGA_MOD, 8'h04);
		host.write_reg(ADDR_MODE_PRI, 8'h05);
		wait_hi(0, 200);
		scan(2'h1, 1'b0, 2'h0, 1'b0);
		wait_hi(0, 50);
		scan(2'h1, 1'b1, 2'h2, 1'b0);
		scan(2'h2, 1'b1, 2'h2, 1'b0);
		scan(2'h3, 1'b1, 2'h2, 1'b1);
		wait_hi(5, 20);
		chk(8'(found), 8'h03);
	endtask

	// slave on config B, then a scan cut short by the timer
	task automatic t_switch();
		host.write_reg(ADDR_MODE_PRI, 8'h0A);
		wait_hi(4, 100);
		chk(8'({cfg_b, mod_t, syn_ch}), 8'h19);
		host.write_reg(ADDR_MODE_PRI, 8'h01);
		wait_hi(0, 200);
		wait_hi(1, 10);
		rx_run = 1'b0;
		tick(2);
		rx_run = 1'b1;
		wait_hi(0, 200);
		scan(2'h1, 1'b0, 2'h0, 1'b1);
		wait_hi(5, 20);
		chk(8'(found), 8'h01);
	endtask

	// reset, then the scenarios in turn
	initial
	begin
		rstn = 1'b0;
		rx_run = 1'b0;
		s_done = 1'b0;
		wk_found = 1'b0;
		tick(8);
		rstn = 1'b1;
		tick(4);
		t_reset();
		t_slave();
		t_poll_one();
		t_poll_two();
		t_switch();
		complete_run();
	end
endmodule
